// >>> hw/flac_cfg.svh
// Address map, field codes and timing figures of the flash array front end.
`ifndef FLAC_CFG_SVH
`define FLAC_CFG_SVH
`define FLAC_KB_WORDS        32'h0000_0100
`define FLAC_SEC_ADDR        32'h0010_0000
`define FLAC_TRIM_ADDR       32'h0010_1004
`define FLAC_SECT_B_BASE     32'h0000_4000
`define FLAC_SECT48_BASE     32'h0000_8000
`define FLAC_SECT64_BASE     32'h0002_0000
`define FLAC_SECT64_SHIFT    17
`define FLAC_SECT64_FIRST    7'h03
`define FLAC_ROW_HALF_BIT    2
`define FLAC_HALF_SEL_BIT    1
`define FLAC_WORD_SHIFT      2
`define FLAC_WIDTH_PROG      2'h1
`define FLAC_WIDTH_ROM       2'h2
`define FLAC_ERASED_WORD     32'hffff_ffff
`define FLAC_CHK_W           7
`define FLAC_PROG_CYCLES     8
`endif

// >>> hw/flac_pkg.sv
// Types shared by the flash array front end and its checker, host model and bench.
package flac_pkg;
   typedef enum logic {flac_rom, flac_prog} flac_mode_t;
   typedef enum logic [1:0] {flac_op_read, flac_op_program, flac_op_erase_sector,
                             flac_op_erase_chip} flac_op_t;
   typedef enum logic [1:0] {flac_idle, flac_programming, flac_erasing} flac_alg_t;

   // One access request from the core or from the ROM writer.
   typedef struct packed {
      logic        valid;
      flac_op_t    op;
      logic        word;
      logic [31:0] addr;
      logic [15:0] wdata;
   } flac_req_t;

   // Answer to a request; every flag is a one-cycle pulse.
   typedef struct packed {
      logic        rvalid;
      logic        refused;
      logic        done;
      logic [31:0] rdata;
   } flac_rsp_t;

   // Complete state of the front end.
   typedef struct packed {
      logic [2:0]  pin_sync;
      logic        writer;
      flac_mode_t  mode;
      flac_alg_t   alg;
      logic [31:0] cnt;
      logic [31:0] idx;
      logic [31:0] addr;
      logic [15:0] hdata;
      logic        chip;
      logic [7:0]  sect;
      flac_rsp_t   rsp;
   } flac_state_t;
endpackage

// >>> hw/flac_ecc.sv
// Single-error-correcting check code: encoder for writes, corrector for reads.
`timescale 1ns/1ps
`default_nettype none
`include "flac_cfg.svh"
module flac_ecc (
   input  wire logic [31:0]            enc_data,
   output logic      [`FLAC_CHK_W-1:0] enc_chk,
   input  wire logic [31:0]            dec_data,
   input  wire logic [`FLAC_CHK_W-1:0] dec_chk,
   output logic      [31:0]            dec_corr
);
   // Codeword position of data bit i, skipping the powers of two.
   function automatic logic [5:0] hpos(input int i);
      int p;
      int n;
      p = 0;
      n = -1;
      while (n < i) begin
         p = p + 1;
         if ((p & (p - 1)) != 0) begin
            n = n + 1;
         end
      end
      return 6'(p);
   endfunction

   logic [5:0] enc_syn;
   logic [5:0] dec_syn;

   // Six position checks plus an overall parity bit; the parity bit is stored
   // but never used for detection, so double flips go unreported.
   always_comb begin
      enc_syn = '0;
      dec_syn = dec_chk[5:0];
      for (int i = 0; i < 32; i++) begin
         if (enc_data[i]) begin
            enc_syn = enc_syn ^ hpos(i);
         end
         if (dec_data[i]) begin
            dec_syn = dec_syn ^ hpos(i);
         end
      end
      enc_chk = {^{enc_data, enc_syn}, enc_syn};
   end

   // Flip the one data bit whose position equals the syndrome.
   for (genvar g = 0; g < 32; g++) begin : g_fix
      assign dec_corr[g] = dec_data[g] ^ (dec_syn == hpos(g));
   end
endmodule
`default_nettype wire

// >>> hw/flac_top.sv
// Flash array front end: access modes, embedded program and erase, check code.
`timescale 1ns/1ps
`default_nettype none
`include "flac_cfg.svh"
module flac_top #(
   parameter int ARRAY_KB    = 1024,
   parameter int PROG_CYCLES = `FLAC_PROG_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire flac_pkg::flac_req_t cpu_req,
   input  wire flac_pkg::flac_req_t writer_req,
   input  wire logic              writer_mode_pin,
   input  wire logic              access_width_wr,
   input  wire logic [1:0]        access_width_field,
   output flac_pkg::flac_rsp_t    rsp,
   output logic                   busy,
   output logic                   prog_mode,
   output logic                   writer_active
);
   import flac_pkg::*;

   localparam int WORDS = ARRAY_KB * int'(`FLAC_KB_WORDS);
   localparam int IDX_W = $clog2(WORDS + 2);
   localparam logic [31:0] ARRAY_BYTES = 32'(WORDS) << `FLAC_WORD_SHIFT;
   localparam logic [IDX_W-1:0] SEC_IDX  = IDX_W'(WORDS);
   localparam logic [IDX_W-1:0] TRIM_IDX = IDX_W'(WORDS + 1);

   flac_state_t st_r;
   flac_state_t st_nxt;

   // Array words plus the security and trimming words, each with its check bits.
   logic [31+`FLAC_CHK_W:0] mem [WORDS+2];

   flac_req_t              rq;
   logic [IDX_W-1:0]       rd_idx;
   logic [31+`FLAC_CHK_W:0] rd_word;
   logic [31:0]            rd_corr;
   logic [31:0]            enc_in;
   logic [`FLAC_CHK_W-1:0] enc_chk;
   logic                   mem_we;
   logic [IDX_W-1:0]       mem_wa;
   logic                   halfmode;

   // Sector number of an address: row range in the upper bits, row half in bit 0.
   function automatic logic [7:0] sect_of(input logic [31:0] a);
      logic [6:0]  r;
      logic [31:0] d;
      d = a - `FLAC_SECT64_BASE;
      if (a < `FLAC_SECT_B_BASE) begin
         r = 7'h00;
      end else if (a < `FLAC_SECT48_BASE) begin
         r = 7'h01;
      end else if (a < `FLAC_SECT64_BASE) begin
         r = 7'h02;
      end else begin
         r = 7'(d >> `FLAC_SECT64_SHIFT) + `FLAC_SECT64_FIRST;
      end
      return {r, a[`FLAC_ROW_HALF_BIT]};
   endfunction

   // Maps a byte address to a storage index; the flag says if it is mapped.
   function automatic logic [IDX_W:0] map_addr(input logic [31:0] a);
      if (a < ARRAY_BYTES) begin
         return {1'b1, IDX_W'(a >> `FLAC_WORD_SHIFT)};
      end else if ((a >> `FLAC_WORD_SHIFT) == (`FLAC_SEC_ADDR >> `FLAC_WORD_SHIFT)) begin
         return {1'b1, SEC_IDX};
      end else if ((a >> `FLAC_WORD_SHIFT) == (`FLAC_TRIM_ADDR >> `FLAC_WORD_SHIFT)) begin
         return {1'b1, TRIM_IDX};
      end
      return '0;
   endfunction

   // One shared corrector on the read port and one encoder on the write port.
   flac_ecc u_ecc (
      .enc_data (enc_in),
      .enc_chk  (enc_chk),
      .dec_data (rd_word[31:0]),
      .dec_chk  (rd_word[31+`FLAC_CHK_W:32]),
      .dec_corr (rd_corr)
   );

   // The ROM writer owns the port while its strap pin is high.
   assign rq       = st_r.writer ? writer_req : cpu_req;
   assign halfmode = st_r.writer || (st_r.mode == flac_prog);
   assign rd_word  = mem[rd_idx];

   // Next-state logic: mode control, request decode and the embedded algorithm.
   always_comb begin
      logic [IDX_W:0] m;
      logic [IDX_W:0] pa;
      logic [31:0]    merged;
      logic           last;
      m        = map_addr(rq.addr);
      pa       = map_addr(st_r.addr);
      merged   = rd_corr;
      last     = 1'b0;
      st_nxt   = st_r;
      st_nxt.rsp = '0;
      mem_we   = 1'b0;
      mem_wa   = m[IDX_W-1:0];
      enc_in   = `FLAC_ERASED_WORD;
      rd_idx   = m[IDX_W-1:0];

      // Strap pin passes three flops; a change counts once the last two agree.
      st_nxt.pin_sync = {st_r.pin_sync[1:0], writer_mode_pin};
      if (st_r.pin_sync[2] == st_r.pin_sync[1]) begin
         st_nxt.writer = st_r.pin_sync[2];
      end

      // Width field: other codes leave the mode unchanged.
      if (access_width_wr) begin
         if (access_width_field == `FLAC_WIDTH_PROG) begin
            st_nxt.mode = flac_prog;
         end else if (access_width_field == `FLAC_WIDTH_ROM) begin
            st_nxt.mode = flac_rom;
         end
      end

      case (st_r.alg)
         flac_idle: begin
            if (rq.valid) begin
               case (rq.op)
                  flac_op_read: begin
                     // Reads answer next cycle whether or not a bit was fixed.
                     if (m[IDX_W] && (rq.word != halfmode)) begin
                        st_nxt.rsp.rvalid = 1'b1;
                        if (rq.word) begin
                           st_nxt.rsp.rdata = rd_corr;
                        end else if (rq.addr[`FLAC_HALF_SEL_BIT]) begin
                           st_nxt.rsp.rdata = {16'h0000, rd_corr[31:16]};
                        end else begin
                           st_nxt.rsp.rdata = {16'h0000, rd_corr[15:0]};
                        end
                     end else begin
                        st_nxt.rsp.refused = 1'b1;
                     end
                  end
                  flac_op_program: begin
                     // Only half-words at even addresses in an algorithm mode.
                     if (halfmode && !rq.word && !rq.addr[0] && m[IDX_W]) begin
                        st_nxt.alg   = flac_programming;
                        st_nxt.addr  = rq.addr;
                        st_nxt.hdata = rq.wdata;
                        st_nxt.cnt   = 32'(PROG_CYCLES - 1);
                     end else begin
                        st_nxt.rsp.refused = 1'b1;
                     end
                  end
                  default: begin
                     if (!halfmode || !m[IDX_W]) begin
                        st_nxt.rsp.refused = 1'b1;
                     end else if (rq.op == flac_op_erase_sector && m[IDX_W-1:0] >= SEC_IDX) begin
                        // The two single words outside the array erase at once.
                        mem_we = 1'b1;
                        st_nxt.rsp.done = 1'b1;
                     end else begin
                        st_nxt.alg  = flac_erasing;
                        st_nxt.chip = (rq.op == flac_op_erase_chip);
                        st_nxt.sect = sect_of(rq.addr);
                        st_nxt.idx  = '0;
                     end
                  end
               endcase
            end
         end
         flac_programming: begin
            // Cells only move from one to zero, so new data is ANDed in.
            rd_idx = pa[IDX_W-1:0];
            mem_wa = rd_idx;
            if (st_r.addr[`FLAC_HALF_SEL_BIT]) begin
               merged[31:16] = rd_corr[31:16] & st_r.hdata;
            end else begin
               merged[15:0] = rd_corr[15:0] & st_r.hdata;
            end
            enc_in = merged;
            if (st_r.cnt == '0) begin
               mem_we = 1'b1;
               st_nxt.alg = flac_idle;
               st_nxt.rsp.done = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - 32'h0000_0001;
            end
            if (rq.valid) begin
               st_nxt.rsp.refused = 1'b1;
            end
         end
         flac_erasing: begin
            // One word per cycle across the array, erasing matching sector words.
            mem_wa = IDX_W'(st_r.idx);
            last   = (st_r.idx == 32'(WORDS - 1));
            if (st_r.chip || sect_of(st_r.idx << `FLAC_WORD_SHIFT) == st_r.sect) begin
               mem_we = 1'b1;
            end
            st_nxt.idx = st_r.idx + 32'h0000_0001;
            if (last) begin
               st_nxt.alg = flac_idle;
               st_nxt.rsp.done = 1'b1;
            end
            if (rq.valid) begin
               st_nxt.rsp.refused = 1'b1;
            end
         end
         default: begin
            st_nxt.alg = flac_idle;
         end
      endcase
   end

   // State register; reset always lands in ROM mode.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r      <= '0;
         st_r.mode <= flac_rom;
         st_r.alg  <= flac_idle;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Array write port; contents are nonvolatile and take no reset.
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= {enc_chk, enc_in};
      end
   end

   assign rsp           = st_r.rsp;
   assign busy          = (st_r.alg != flac_idle);
   assign prog_mode     = (st_r.mode == flac_prog);
   assign writer_active = st_r.writer;
endmodule
`default_nettype wire

// >>> verif/flac_top_asserts.sv
// Port checker for the flash array front end.
`timescale 1ns/1ps
`default_nettype none
`include "flac_cfg.svh"
module flac_top_asserts import flac_pkg::*; #(
   parameter int ARRAY_KB    = 1024,
   parameter int PROG_CYCLES = 8
) (
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire flac_pkg::flac_req_t cpu_req,
   input wire flac_pkg::flac_req_t writer_req,
   input wire logic                writer_mode_pin,
   input wire logic                access_width_wr,
   input wire logic [1:0]          access_width_field,
   input wire flac_pkg::flac_rsp_t rsp,
   input wire logic                busy,
   input wire logic                prog_mode,
   input wire logic                writer_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Request in force and whether half-word access applies.
   wire flac_req_t rq = writer_active ? writer_req : cpu_req;
   wire logic      pm = prog_mode | writer_active;
   wire logic      odd = rq.addr >= 32'(ARRAY_KB * 1024)
                         && (rq.addr >> 2) != (`FLAC_SEC_ADDR >> 2)
                         && (rq.addr >> 2) != (`FLAC_TRIM_ADDR >> 2);
   a_read_next: assert property (rq.valid && rq.op == flac_op_read |=> rsp.rvalid ^ rsp.refused)
      else $error("read not answered in next cycle");
   a_rom_locked: assert property (rq.valid && !pm && (rq.op != flac_op_read || !rq.word)
      |=> rsp.refused) else $error("rom mode accepted a forbidden access");
   a_prog_noword: assert property (rq.valid && pm && rq.op == flac_op_read && rq.word
      |=> rsp.refused) else $error("word read accepted in programming mode");
   a_half_only: assert property (rq.valid && rq.op == flac_op_program
      && (rq.word || rq.addr[0]) |=> rsp.refused) else $error("non half-word program accepted");
   a_width_prog: assert property (access_width_wr && access_width_field == 2'h1 |=> prog_mode)
      else $error("code 01 did not select programming mode");
   a_width_rom: assert property (access_width_wr && access_width_field == 2'h2 |=> !prog_mode)
      else $error("code 10 did not select rom mode");
   a_unmapped_ref: assert property (rq.valid && odd |=> rsp.refused)
      else $error("unmapped address accepted");
   a_prog_busy: assert property (!busy && rq.valid && pm && rq.op == flac_op_program
      && !rq.word && !rq.addr[0] && !odd |=> busy) else $error("accepted program did not start");
   a_done_busy: assert property ($fell(busy) |-> rsp.done)
      else $error("algorithm ended without done");
   a_reset_rom: assert property ($fell(rst) |-> !prog_mode && !busy)
      else $error("reset did not return to rom mode");
   c_done: cover property (rsp.done);
   c_read: cover property (rsp.rvalid && writer_active);
   c_refuse: cover property (rsp.refused && prog_mode);
endmodule
bind flac_top flac_top_asserts #(.ARRAY_KB(ARRAY_KB), .PROG_CYCLES(PROG_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .writer_req(writer_req),
   .writer_mode_pin(writer_mode_pin), .access_width_wr(access_width_wr),
   .access_width_field(access_width_field), .rsp(rsp), .busy(busy),
   .prog_mode(prog_mode), .writer_active(writer_active));
`default_nettype wire

// >>> verif/flac_host_model.sv
// Model of the core bus and the ROM writer that issue requests.
`timescale 1ns/1ps
`default_nettype none
module flac_host_model import flac_pkg::*; (
   input  wire flac_pkg::flac_rsp_t rsp,
   input  wire logic                ref_clk,
   output var flac_pkg::flac_req_t  cpu_req,
   output var flac_pkg::flac_req_t  writer_req,
   output var logic                 writer_mode_pin,
   output var logic                 access_width_wr,
   output var logic [1:0]           access_width_field
);
   // Everything idle at time zero.
   initial begin
      cpu_req = '0;
      writer_req = '0;
      writer_mode_pin = 1'b0;
      access_width_wr = 1'b0;
      access_width_field = 2'h0;
   end
   // One request held for its taking edge; a released bus shows inverted address and data.
   task automatic acc(input logic w, input flac_op_t op, input logic wd, input logic [31:0] a,
                      input logic [15:0] d, output logic [31:0] k, output logic [31:0] n,
                      output logic [31:0] q);
      flac_req_t r;
      r = '{valid: 1'b1, op: op, word: wd, addr: a, wdata: d};
      k = 32'h3;
      q = 32'h0;
      @(posedge ref_clk);
      #1;
      if (w) writer_req = r;
      else cpu_req = r;
      for (n = 32'h1; n <= 32'd2000; n++) begin
         @(posedge ref_clk);
         #1;
         r = '{valid: 1'b0, op: op, word: wd, addr: ~a, wdata: ~d};
         if (w) writer_req = r;
         else cpu_req = r;
         if (rsp.rvalid | rsp.refused | rsp.done) begin
            k = rsp.rvalid ? 32'h0 : (rsp.refused ? 32'h1 : 32'h2);
            q = rsp.rdata;
            break;
         end
      end
   endtask
   // One-cycle write of the access width field.
   task automatic width(input logic [1:0] v);
      @(posedge ref_clk);
      #1;
      access_width_wr = 1'b1;
      access_width_field = v;
      @(posedge ref_clk);
      #1;
      access_width_wr = 1'b0;
      access_width_field = ~v;
   endtask
   // Writer strap level.
   task automatic strap(input logic v);
      @(posedge ref_clk);
      #1;
      writer_mode_pin = v;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the flash array front end.
`timescale 1ns/1ps
`default_nettype none
`include "flac_cfg.svh"
module tb_top;
   import flac_pkg::*;
   localparam int PC = 4;
   localparam logic [31:0] K_REF = 32'h1;
   localparam logic [31:0] K_DONE = 32'h2;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   flac_req_t   cpu_req;
   flac_req_t   writer_req;
   logic        pin;
   logic        wr;
   logic [1:0]  fld;
   flac_rsp_t   rsp;
   logic        busy;
   logic        prog_mode;
   logic        writer_active;
   logic [31:0] k;
   logic [31:0] n;
   logic [31:0] q;
   int          errors = 0;
   int          n_compared = 0;
   // Clock of 50 ns period.
   always #25 ref_clk = ~ref_clk;
   flac_host_model u_host (.rsp(rsp), .ref_clk(ref_clk), .cpu_req(cpu_req),
      .writer_req(writer_req), .writer_mode_pin(pin), .access_width_wr(wr),
      .access_width_field(fld));
   flac_top #(.ARRAY_KB(1), .PROG_CYCLES(PC)) u_dut (.ref_clk(ref_clk), .rst(rst),
      .cpu_req(cpu_req), .writer_req(writer_req), .writer_mode_pin(pin),
      .access_width_wr(wr), .access_width_field(fld), .rsp(rsp), .busy(busy),
      .prog_mode(prog_mode), .writer_active(writer_active));
   task automatic complete_run;
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   // One request; a hung answer ends the run.
   task automatic rq(input logic w, input flac_op_t op, input logic wd, input logic [31:0] a,
                     input logic [15:0] d);
      u_host.acc(w, op, wd, a, d, k, n, q);
      if (k === 32'h3) begin
         errors++;
         complete_run();
      end
   endtask
   // Bounded wait for the synced strap to reach a level.
   task automatic wait_strap(input logic v);
      for (int i = 0; i < 8 && writer_active !== v; i++) @(posedge ref_clk);
      chkb("writer_active", v, writer_active);
      if (writer_active !== v) begin
         complete_run();
      end
   endtask
   task automatic t_rom;
      chkb("prog_mode", 1'b0, prog_mode);
      rq(0, flac_op_program, 0, 32'h0, 16'h0);
      chk("rom_program", K_REF, k);
      rq(0, flac_op_read, 0, 32'h0, 16'h0);
      chk("rom_half", K_REF, k);
   endtask
   task automatic t_erase;
      u_host.width(2'h1);
      chkb("prog_mode", 1'b1, prog_mode);
      u_host.width(2'h3);
      chkb("width_other", 1'b1, prog_mode);
      rq(0, flac_op_erase_chip, 0, 32'h0, 16'h0);
      chk("chip_cycles", 32'd257, n);
      rq(0, flac_op_read, 0, 32'h2, 16'h0);
      chk("erased_half", 32'h0000_ffff, q);
      rq(0, flac_op_read, 1, 32'h0, 16'h0);
      chk("prog_word", K_REF, k);
   endtask
   task automatic t_program;
      // Busy is sampled one step after the edge that takes the program request.
      fork
         rq(0, flac_op_program, 0, 32'h2, 16'h1234);
         begin
            repeat (2) @(posedge ref_clk);
            #1;
            chkb("busy", 1'b1, busy);
         end
      join
      chk("prog_cycles", PC + 1, n);
      rq(0, flac_op_read, 0, 32'h2, 16'h0);
      chk("prog_half", 32'h0000_1234, q);
      rq(0, flac_op_program, 1, 32'h4, 16'h0);
      chk("prog_wide", K_REF, k);
      rq(0, flac_op_program, 0, 32'h5, 16'h0);
      chk("prog_odd", K_REF, k);
   endtask
   task automatic t_special;
      rq(0, flac_op_erase_sector, 0, `FLAC_SEC_ADDR, 16'h0);
      chk("sec_erase", 32'h1, n);
      rq(0, flac_op_read, 0, `FLAC_SEC_ADDR, 16'h0);
      chk("sec_half", 32'h0000_ffff, q);
      rq(0, flac_op_erase_sector, 0, `FLAC_TRIM_ADDR, 16'h0);
      chk("trim_erase", K_DONE, k);
      rq(0, flac_op_read, 0, `FLAC_TRIM_ADDR + 32'h2, 16'h0);
      chk("trim_half", 32'h0000_ffff, q);
      rq(0, flac_op_read, 0, 32'h400, 16'h0);
      chk("unmapped", K_REF, k);
   endtask
   task automatic t_word;
      u_host.width(2'h2);
      chkb("prog_mode", 1'b0, prog_mode);
      rq(0, flac_op_read, 1, 32'h0, 16'h0);
      chk("word_latency", 32'h1, n);
      chk("word_data", 32'h1234_ffff, q);
      // One stored bit flipped is corrected; two flipped bits still answer without a flag.
      u_dut.mem[0] = u_dut.mem[0] ^ 39'h00_0001_0000;
      rq(0, flac_op_read, 1, 32'h0, 16'h0);
      chk("one_flip", 32'h1234_ffff, q);
      u_dut.mem[0] = u_dut.mem[0] ^ 39'h00_0002_0000;
      rq(0, flac_op_read, 1, 32'h0, 16'h0);
      chk("two_flip_kind", 32'h0, k);
      u_dut.mem[0] = u_dut.mem[0] ^ 39'h00_0003_0000;
   endtask
   task automatic t_writer;
      u_host.strap(1'b1);
      wait_strap(1'b1);
      rq(1, flac_op_read, 1, 32'h0, 16'h0);
      chk("writer_word", K_REF, k);
      rq(1, flac_op_program, 0, 32'h0, 16'h00ff);
      chk("writer_prog", K_DONE, k);
      rq(1, flac_op_read, 0, 32'h0, 16'h0);
      chk("writer_half", 32'h0000_00ff, q);
      u_host.strap(1'b0);
      wait_strap(1'b0);
   endtask
   task automatic t_reset;
      u_host.width(2'h1);
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      chkb("prog_mode", 1'b0, prog_mode);
   endtask
   // Main sequence.
   initial begin
      repeat (10) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_rom();
      t_erase();
      t_program();
      t_special();
      t_word();
      t_writer();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
